// ==== verilog/cfr_regs.sv ====
// control registers, serial port and strobe gating of the ccd front end
//
// Operation
// - serial port and registers writable in active and stand-by mode
// - mode bit: 0 active, 1 stand-by
// - polarity bits set each strobe level
// - delay field picks extra output delay
// - reset pin loads all defaults
// - reset clears mode to active
// - reset loads gain code 0x100
// - reset loads clamp code 1000
// - reset makes all strobes active low
// - reset clears output delay to zero
// - output words change with converter clock
// - stand-by forces internal strobes high and converter clock enable low
// - ten-bit gain code sets amplifier gain
// - shift data on rising shift clock, 16 bits
// - load edge latches, registers follow 5-6 clocks
// - word: test, address, twelve data bits
// - clamp code n gives 2+16n pedestal
`timescale 1ns/1ns

module cfr_regs #(
	parameter int DATA_W = 12
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic serial_clk,
	input wire logic serial_load_strobe,
	input wire logic serial_data_in,
	input wire cfr_pkg::cfr_pulses_t pulses_pin,
	input wire logic [DATA_W-1:0] adc_word,
	output cfr_pkg::cfr_cfg_t cfg,
	output cfr_pkg::cfr_pulses_t pulses_int,
	output logic converter_clock_enable,
	output logic [DATA_W-1:0] data_out,
	output logic [cfr_pkg::PEDESTAL_W-1:0] black_pedestal
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic cmd_valid(input logic [cfr_pkg::WORD_W-1:0] w);
		cmd_valid = !w[cfr_pkg::TEST_BIT] && (w[cfr_pkg::ADDR_HI:cfr_pkg::ADDR_LO] <= cfr_pkg::ADDR_LAST_USED);
	endfunction : cmd_valid

	function automatic logic [cfr_pkg::PEDESTAL_W-1:0] pedestal_of(input logic [cfr_pkg::CLAMP_W-1:0] code);
		pedestal_of = cfr_pkg::PEDESTAL_BASE + ((cfr_pkg::PEDESTAL_W)'(code) << cfr_pkg::PEDESTAL_SHIFT);
	endfunction : pedestal_of

	////////////////////////////////////////////////////////////////////////////////
	// link side, on the shift clock

	logic [cfr_pkg::WORD_W-1:0] shift_word;

	// shift on rise
	// held still while the strobe is high, which is what lets the core read it
	always_ff @(posedge serial_clk) begin
		if (!serial_load_strobe) begin
			shift_word <= {shift_word[cfr_pkg::WORD_W-2:0], serial_data_in};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// load strobe crossing

	logic load_s1;
	logic load_s2;
	logic load_s3;
	logic load_rise;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			load_s1 <= 1'h1;
			load_s2 <= 1'h1;
			load_s3 <= 1'h1;
		end else begin
			load_s1 <= serial_load_strobe;
			load_s2 <= load_s1;
			load_s3 <= load_s2;
		end
	end

	assign load_rise = load_s2 && !load_s3;

	////////////////////////////////////////////////////////////////////////////////
	// parallel latch and transfer delay

	logic [cfr_pkg::WORD_W-1:0] par_latch;
	logic [cfr_pkg::XFER_STAGES-1:0] xfer_pipe;
	logic apply_now;
	logic [2:0] latch_addr;
	logic [cfr_pkg::DATA_HI:0] latch_data;

	// latch shifted word
	// a new load while one is in flight wins; the host spaces loads by 16 shifts
	always_ff @(posedge core_clk) begin
		if (srst) begin
			par_latch <= '0;
		end else if (load_rise) begin
			par_latch <= shift_word;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			xfer_pipe <= '0;
		end else begin
			xfer_pipe <= {xfer_pipe[cfr_pkg::XFER_STAGES-2:0], load_rise};
		end
	end

	assign apply_now = xfer_pipe[cfr_pkg::XFER_STAGES-1];
	assign latch_addr = par_latch[cfr_pkg::ADDR_HI:cfr_pkg::ADDR_LO];
	assign latch_data = par_latch[cfr_pkg::DATA_HI:cfr_pkg::DATA_LO];

	////////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfg.standby <= cfr_pkg::RST_MODE;
			cfg.gain <= cfr_pkg::RST_GAIN;
			cfg.clamp_level <= cfr_pkg::RST_CLAMP;
			cfg.polarity <= cfr_pkg::RST_POLARITY;
			cfg.out_delay <= cfr_pkg::RST_DELAY;
		end else if (apply_now && cmd_valid(par_latch)) begin
			case (latch_addr)
				cfr_pkg::ADDR_MODE: begin
					cfg.standby <= latch_data[0];
				end
				cfr_pkg::ADDR_GAIN: begin
					cfg.gain <= latch_data[cfr_pkg::GAIN_W-1:0];
				end
				cfr_pkg::ADDR_CLAMP: begin
					cfg.clamp_level <= latch_data[cfr_pkg::CLAMP_W-1:0];
				end
				cfr_pkg::ADDR_POLARITY: begin
					cfg.polarity <= latch_data[cfr_pkg::POL_W-1:0];
				end
				cfr_pkg::ADDR_DELAY: begin
					cfg.out_delay <= latch_data[cfr_pkg::DELAY_W-1:0];
				end
				default: begin
					cfg.standby <= cfg.standby;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			black_pedestal <= pedestal_of(cfr_pkg::RST_CLAMP);
		end else begin
			black_pedestal <= pedestal_of(cfg.clamp_level);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// strobe pins: sync, polarity, stand-by mask

	cfr_pkg::cfr_pulses_t pin_s1;
	cfr_pkg::cfr_pulses_t pin_s2;
	cfr_pkg::cfr_pulses_t pol_mask;

	// no reset: the pair keeps tracking the pins, so no false strobe follows reset
	always_ff @(posedge core_clk) begin
		pin_s1 <= pulses_pin;
		pin_s2 <= pin_s1;
	end

	// polarity: one bit for both sample pulses, one each for the black and dummy clamps
	// internal strobes are active low; an active-high pin is inverted here
	assign pol_mask = '{cfg.polarity[cfr_pkg::POL_SAMPLE], cfg.polarity[cfr_pkg::POL_SAMPLE],
		cfg.polarity[cfr_pkg::POL_BLACK], cfg.polarity[cfr_pkg::POL_DUMMY]};

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pulses_int <= '1;
			converter_clock_enable <= 1'h0;
		end else if (cfg.standby) begin
			pulses_int <= '1;
			converter_clock_enable <= 1'h0;
		end else begin
			pulses_int <= cfr_pkg::cfr_pulses_t'(pin_s2 ^ pol_mask);
			converter_clock_enable <= 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// output data

	// converter-clocked output
	// zero in stand-by; sub-cycle delay is left to the pad delay line via cfg.out_delay
	always_ff @(posedge core_clk) begin
		if (srst || cfg.standby) begin
			data_out <= '0;
		end else begin
			data_out <= adc_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_reset_defaults: assert property (@(posedge core_clk) disable iff (1'b0)
		srst |=> (cfg == cfr_pkg::RST_CFG))
		else $error("defaults not loaded by reset");

	a_reset_mode: assert property (@(posedge core_clk) disable iff (1'b0)
		srst |=> !cfg.standby && data_out == '0 && pulses_int == '1 && !converter_clock_enable)
		else $error("reset did not leave active mode");

	a_xfer_latency: assert property (load_rise |-> ##3 apply_now)
		else $error("load not applied three clocks after edge");

	a_latch_capture: assert property (load_rise |=> par_latch == $past(shift_word))
		else $error("shifted word not latched on load edge");

	a_reserved_ignored: assert property (apply_now && !cmd_valid(par_latch) |=> $stable(cfg))
		else $error("invalid word changed a register");

	a_gain_write: assert property (apply_now && cmd_valid(par_latch) && latch_addr == cfr_pkg::ADDR_GAIN
		|=> cfg.gain == $past(latch_data[cfr_pkg::GAIN_W-1:0]))
		else $error("gain word not stored");

	a_mode_write: assert property (apply_now && cmd_valid(par_latch) && latch_addr == cfr_pkg::ADDR_MODE
		|=> cfg.standby == $past(latch_data[0]))
		else $error("mode word not stored");

	a_clamp_write: assert property (apply_now && cmd_valid(par_latch) && latch_addr == cfr_pkg::ADDR_CLAMP
		|=> cfg.clamp_level == $past(latch_data[cfr_pkg::CLAMP_W-1:0]))
		else $error("clamp word not stored");

	a_polarity_write: assert property (apply_now && cmd_valid(par_latch) && latch_addr == cfr_pkg::ADDR_POLARITY
		|=> cfg.polarity == $past(latch_data[cfr_pkg::POL_W-1:0]))
		else $error("polarity word not stored");

	a_delay_write: assert property (apply_now && cmd_valid(par_latch) && latch_addr == cfr_pkg::ADDR_DELAY
		|=> cfg.out_delay == $past(latch_data[cfr_pkg::DELAY_W-1:0]))
		else $error("delay word not stored");

	a_standby_mask: assert property (cfg.standby |=> pulses_int == '1 && !converter_clock_enable)
		else $error("strobes not masked high in stand-by");

	a_standby_data: assert property (cfg.standby |=> data_out == '0)
		else $error("output not zero in stand-by");

	a_clock_enable: assert property (!srst && !cfg.standby |=> converter_clock_enable)
		else $error("converter clock masked while active");

	a_polarity_map: assert property (!srst && !cfg.standby |=>
		pulses_int.black_clamp == ($past(pin_s2.black_clamp) ^ $past(cfg.polarity[cfr_pkg::POL_BLACK])))
		else $error("black clamp polarity wrong");

	a_dummy_polarity: assert property (!srst && !cfg.standby |=>
		pulses_int.dummy_clamp == ($past(pin_s2.dummy_clamp) ^ $past(cfg.polarity[cfr_pkg::POL_DUMMY])))
		else $error("dummy clamp polarity wrong");

	a_sample_polarity: assert property (!srst && !cfg.standby |=>
		pulses_int.reference_sample == ($past(pin_s2.reference_sample) ^ $past(cfg.polarity[cfr_pkg::POL_SAMPLE]))
		&& pulses_int.pixel_sample == ($past(pin_s2.pixel_sample) ^ $past(cfg.polarity[cfr_pkg::POL_SAMPLE])))
		else $error("sample pulse polarity wrong");

	a_data_follow: assert property (!srst && !cfg.standby |=> data_out == $past(adc_word))
		else $error("output word not registered from converter");

	a_pedestal_value: assert property (##1 black_pedestal == 8'h02 + 8'h10 * $past(cfg.clamp_level))
		else $error("pedestal does not match clamp code");

	a_shift_in: assert property (@(posedge serial_clk) disable iff (1'b0)
		!serial_load_strobe |=> shift_word[0] == $past(serial_data_in))
		else $error("serial bit not shifted in on rising edge");

	c_gain_write: cover property (apply_now && cmd_valid(par_latch) && latch_addr == cfr_pkg::ADDR_GAIN);
	c_reserved_drop: cover property (apply_now && !cmd_valid(par_latch));
	c_write_in_standby: cover property (cfg.standby && apply_now && cmd_valid(par_latch));
	c_standby_exit: cover property (cfg.standby ##1 !cfg.standby);
	c_load_edge: cover property (load_rise);

endmodule : cfr_regs

// ==== verilog/cfr_pkg.sv ====
// constants and types of the ccd front-end control registers
package cfr_pkg;

	// serial word layout, msb first
	localparam int WORD_W = 16;
	localparam int TEST_BIT = 15;
	localparam int ADDR_HI = 14;
	localparam int ADDR_LO = 12;
	localparam int DATA_HI = 11;
	localparam int DATA_LO = 0;

	// register addresses carried in the word
	localparam logic [2:0] ADDR_MODE = 3'h0;
	localparam logic [2:0] ADDR_GAIN = 3'h1;
	localparam logic [2:0] ADDR_CLAMP = 3'h2;
	localparam logic [2:0] ADDR_POLARITY = 3'h3;
	localparam logic [2:0] ADDR_DELAY = 3'h4;
	localparam logic [2:0] ADDR_LAST_USED = 3'h4;

	// field widths
	localparam int GAIN_W = 10;
	localparam int CLAMP_W = 4;
	localparam int POL_W = 3;
	localparam int DELAY_W = 2;
	localparam int PEDESTAL_W = 8;

	// polarity bit positions
	localparam int POL_DUMMY = 0;
	localparam int POL_BLACK = 1;
	localparam int POL_SAMPLE = 2;

	// reset values
	localparam logic RST_MODE = 1'h0;
	localparam logic [9:0] RST_GAIN = 10'h100;
	localparam logic [3:0] RST_CLAMP = 4'h8;
	localparam logic [2:0] RST_POLARITY = 3'h0;
	localparam logic [1:0] RST_DELAY = 2'h0;

	// pedestal = base + step * code, in output lsb
	localparam logic [7:0] PEDESTAL_BASE = 8'h02;
	localparam int PEDESTAL_SHIFT = 4;

	// converter clocks from the synchronised load edge to the register write
	localparam int XFER_STAGES = 3;

	// extra output delay per code, ns, handed to the analog delay line
	localparam int DELAY_NS_1 = 5;
	localparam int DELAY_NS_2 = 10;
	localparam int DELAY_NS_3 = 13;

	typedef struct packed {
		logic standby;
		logic [9:0] gain;
		logic [3:0] clamp_level;
		logic [2:0] polarity;
		logic [1:0] out_delay;
	} cfr_cfg_t;

	typedef struct packed {
		logic reference_sample;
		logic pixel_sample;
		logic black_clamp;
		logic dummy_clamp;
	} cfr_pulses_t;

	localparam cfr_cfg_t RST_CFG = '{RST_MODE, RST_GAIN, RST_CLAMP, RST_POLARITY, RST_DELAY};

endpackage : cfr_pkg

// ==== bench/cfr_host_model.sv ====
// host model writing words over the three-wire serial port
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module cfr_host_model (
	output logic serial_clk,
	output logic serial_load_strobe,
	output logic serial_data_in
);
	// link clock stands still outside frames
	initial begin
		serial_clk = 1'b0;
		serial_load_strobe = 1'b1;
		serial_data_in = 1'b0;
	end

	task automatic send(input logic [15:0] word);
		serial_load_strobe = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_data_in = word[i];
			#80 serial_clk = 1'b1;
			#80 serial_clk = 1'b0;
		end
		#80 serial_load_strobe = 1'b1;
		// released line shows the inverse, never a stale bit
		serial_data_in = ~serial_data_in;
	endtask : send
endmodule : cfr_host_model

// ==== bench/test_cfr_regs.sv ====
// self-checking bench of the ccd front-end control registers
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////
module test_cfr_regs;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	cfr_pkg::cfr_pulses_t pulses_pin = 4'hf;
	logic [11:0] adc_word = 12'h000;
	logic serial_clk;
	logic serial_load_strobe;
	logic serial_data_in;
	cfr_pkg::cfr_cfg_t cfg;
	cfr_pkg::cfr_pulses_t pulses_int;
	logic converter_clock_enable;
	logic [11:0] data_out;
	logic [7:0] black_pedestal;
	int mismatches = 0;
	int n_checks = 0;

	always #5 core_clk = ~core_clk;

	cfr_host_model i_cfr_host_model (
		.serial_clk(serial_clk),
		.serial_load_strobe(serial_load_strobe),
		.serial_data_in(serial_data_in)
	);

	cfr_regs #(.DATA_W(12)) i_cfr_regs (
		.core_clk(core_clk),
		.srst(srst),
		.serial_clk(serial_clk),
		.serial_load_strobe(serial_load_strobe),
		.serial_data_in(serial_data_in),
		.pulses_pin(pulses_pin),
		.adc_word(adc_word),
		.cfg(cfg),
		.pulses_int(pulses_int),
		.converter_clock_enable(converter_clock_enable),
		.data_out(data_out),
		.black_pedestal(black_pedestal)
	);
////////////////////////////////////////////////////////////////
	task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %0t %s: %h, wanted %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [11:0] d, input logic t);
		i_cfr_host_model.send({t, a, d});
		repeat (7) @(posedge core_clk);
		#1;
	endtask : wr

	task automatic wrap_up;
		if (mismatches == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// hang guard well past the expected run of about 30 us
	initial begin
		#500000;
		mismatches++;
		wrap_up();
	end
////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		// no blanking input here, so clamp pins are free to move
		pulses_pin <= 4'h6;
		adc_word <= 12'h5a3;
		#1;
		check(pulses_int, 4'hf, "strobes in reset");
		@(posedge core_clk);
		#1;
		check(cfg, {1'h0, 10'h100, 4'h8, 3'h0, 2'h0}, "defaults");
		check(black_pedestal, 8'h82, "default pedestal");
		check(pulses_int, 4'hf, "no false strobe after reset");
		check(data_out, 12'h5a3, "data one clock late");
		check(converter_clock_enable, 1'h1, "clock runs");
		repeat (2) @(posedge core_clk);
		#1;
		check(pulses_int, 4'h6, "active low strobes");
		i_cfr_host_model.send(16'h13a5);
		repeat (5) @(posedge core_clk);
		#1;
		check(cfg.gain, 10'h100, "gain too early");
		repeat (1) @(posedge core_clk);
		#1;
		check(cfg.gain, 10'h3a5, "gain written");
		wr(3'h2, 12'hfff, 1'b0);
		wr(3'h3, 12'h005, 1'b0);
		wr(3'h4, 12'h003, 1'b0);
		check(cfg, {1'h0, 10'h3a5, 4'hf, 3'h5, 2'h3}, "all fields");
		check(black_pedestal, 8'hf2, "top pedestal");
		check(pulses_int, 4'hb, "polarity inverts");
		wr(3'h5, 12'h000, 1'b0);
		wr(3'h7, 12'h000, 1'b0);
		wr(3'h1, 12'h000, 1'b1);
		check(cfg, {1'h0, 10'h3a5, 4'hf, 3'h5, 2'h3}, "ignored words");
		wr(3'h0, 12'h001, 1'b0);
		check(pulses_int, 4'hf, "standby mask");
		check(converter_clock_enable, 1'h0, "clock masked");
		check(data_out, 12'h000, "standby output");
		wr(3'h2, 12'h000, 1'b0);
		check(black_pedestal, 8'h02, "write in standby");
		wr(3'h0, 12'h000, 1'b0);
		repeat (3) @(posedge core_clk);
		#1;
		check(converter_clock_enable, 1'h1, "back to active");
		check(pulses_int, 4'hb, "strobes back");
		@(posedge core_clk);
		srst <= 1'b1;
		@(posedge core_clk);
		@(posedge core_clk);
		srst <= 1'b0;
		#1;
		check(cfg, {1'h0, 10'h100, 4'h8, 3'h0, 2'h0}, "mid-run reset");
		check(pulses_int, 4'hf, "strobes masked in reset");
		check(converter_clock_enable, 1'h0, "clock masked in reset");
		@(posedge core_clk);
		#1;
		check(pulses_int, 4'h6, "strobes after reset");
		check(data_out, 12'h5a3, "data after reset");
		wr(3'h3, 12'h002, 1'b0);
		check(pulses_int, 4'h4, "black clamp inverts");
		wrap_up();
	end
endmodule : test_cfr_regs
